// >>> src/sbb_defs.vh
// Constants for the bit-bang serial port select block
// Summary of operation
// RQ1 - Software reaches serial peripherals only through the write, select and read ports.
// RQ2 - Reading the read-data port returns the EEPROM serial output in bit zero.
// RQ3 - The same read bit also carries the EEPROM busy indication.
// RQ4 - Writing the write-data port shifts written bit zero into the selected peripheral.
// RQ5 - Software programs the select register before sending serial data bits.
// RQ6 - The write-only select byte chooses the serial target; bits 7 to 4 unused.
// RQ7 - Converter outputs take the shift word only on a 0-to-1 load transition.
// RQ8 - With load held low both analog outputs stay unchanged.
// RQ9 - A load updates only channels flagged by the two target bits.
// RQ10 - Software returns load to zero before shifting new converter data.
// RQ11 - EEPROM select high lets the EEPROM respond; low makes it ignore the bus.
// RQ12 - Pot select high lets the pot chip respond; low makes it ignore the bus.
// RQ13 - Converter select high lets the converter accept writes only; low ignores.
// RQ14 - Four calibration pots and two output channel data registers are provided.
// RQ15 - EEPROM access is eeprom_operation, address, write data; read data returns serially.
// RQ16 - Each write-data write makes exactly one serial clock pulse, data stable.
// RQ17 - Select and load bits are static levels held until rewritten.
`ifndef SBB_DEFS_VH
`define SBB_DEFS_VH

// Host I/O port addresses
`define SBB_ADDR_W 10
`define SBB_SELECT_ADDR 10'h308
`define SBB_DATA_ADDR 10'h309

// Select and load register fields
`define SBB_SEL_CONV_BIT 0
`define SBB_SEL_POT_BIT 1
`define SBB_SEL_EE_BIT 2
`define SBB_SEL_LOAD_BIT 3
`define SBB_SEL_RESET 4'h0

// Converter shift word layout: target bits then data
`define SBB_CONV_WORD_W 14
`define SBB_CONV_A_BIT 13
`define SBB_CONV_B_BIT 12
`define SBB_CONV_DATA_W 12

// Pot shift word layout: index then wiper value
`define SBB_POT_WORD_W 10
`define SBB_POT_VAL_W 8

// Serial clock timing
`define SBB_CLK_PERIOD_NS 50
`define SBB_SCLK_HALF_NS 200
`define SBB_SCLK_HALF_CYC ((`SBB_SCLK_HALF_NS + `SBB_CLK_PERIOD_NS - 1) / `SBB_CLK_PERIOD_NS)

// Queue entry: flag bit plus four payload bits
`define SBB_Q_W 5
`define SBB_Q_DEPTH 16

`endif

// >>> src/sbb_fifo.v
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sbb_fifo #(
    parameter WIDTH = 5,
    parameter DEPTH = 16
) (
    // Clock and reset
    input wire core_clk,
    input wire reset_n,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;

    assign in_ready = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge core_clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (push && !pop)
            begin
                count <= count + 1'b1;
            end
            else if (pop && !push)
            begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // sbb_fifo

// >>> src/sbb_serial_port.v
// Host port front end of the on-board bit-bang serial bus
`timescale 1ns/1ps
`include "sbb_defs.vh"
module sbb_serial_port #(
    parameter FIFO_DEPTH = `SBB_Q_DEPTH,
    parameter SCLK_HALF_CYC = `SBB_SCLK_HALF_CYC
) (
    // Clock and reset
    input wire core_clk,
    input wire reset_n,
    // Host I/O port
    input wire [`SBB_ADDR_W-1:0] io_addr,
    input wire io_wr,
    input wire io_rd,
    input wire [7:0] io_wdata,
    output reg [7:0] io_rdata,
    output wire io_ready,
    // Serial bus toward peripherals
    output reg serial_clk,
    output reg serial_data_out,
    input wire serial_data_in,
    output reg eeprom_select,
    output reg pot_select,
    output reg converter_select,
    output reg converter_update_strobe,
    // Converter outputs
    output reg [`SBB_CONV_DATA_W-1:0] out0_value,
    output reg [`SBB_CONV_DATA_W-1:0] out1_value,
    // Calibration pots
    output reg [`SBB_POT_VAL_W-1:0] input_offset_pot,
    output reg [`SBB_POT_VAL_W-1:0] out0_gain_pot,
    output reg [`SBB_POT_VAL_W-1:0] input_gain_pot,
    output reg [`SBB_POT_VAL_W-1:0] out1_gain_pot,
    // Engine status
    output wire serial_busy
);
    localparam ST_IDLE = 2'b00;
    localparam ST_LOW = 2'b01;
    localparam ST_HIGH = 2'b10;
    localparam [7:0] HALF = SCLK_HALF_CYC[7:0];

    // Queue entries: bit 4 set means a select write, clear means a data bit
    wire wr_select;
    wire wr_data;
    wire [`SBB_Q_W-1:0] q_in_data;
    wire q_in_valid;
    wire q_in_ready_w;
    wire q_out_valid;
    wire [`SBB_Q_W-1:0] q_out_data;
    reg q_out_ready;

    reg [1:0] state;
    reg [1:0] next_state;
    reg [7:0] half_cnt;
    reg miso_meta;
    reg miso_sync;
    reg [`SBB_CONV_WORD_W-1:0] converter_shift_word;
    reg [`SBB_POT_WORD_W-1:0] pot_shift_word;
    wire [3:0] new_sel;
    wire load_rise;
    wire pot_release;
    wire sclk_rise;

    assign wr_select = io_wr && (io_addr == `SBB_SELECT_ADDR);
    assign wr_data = io_wr && (io_addr == `SBB_DATA_ADDR);
    assign q_in_valid = wr_select || wr_data;
    // RQ6 select byte
    assign q_in_data = wr_select ? {1'b1, io_wdata[3:0]} : {1'b0, 3'h0, io_wdata[0]};
    // Host must stretch its cycle while the queue is full, or the write is lost
    assign io_ready = q_in_ready_w;

    sbb_fifo #(
        .WIDTH(`SBB_Q_W),
        .DEPTH(FIFO_DEPTH)
    ) u_queue (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .in_valid(q_in_valid),
        .in_ready(q_in_ready_w),
        .in_data(q_in_data),
        .out_valid(q_out_valid),
        .out_ready(q_out_ready),
        .out_data(q_out_data)
    );

    assign serial_busy = q_out_valid || (state != ST_IDLE);

    // Read bit crosses from the pins; second stage alone feeds logic
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            miso_meta <= 1'b0;
            miso_sync <= 1'b0;
        end
        else
        begin
            miso_meta <= serial_data_in;
            miso_sync <= miso_meta;
        end
    end

    // RQ2 read bit zero
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            io_rdata <= 8'h00;
        end
        else if (io_rd && io_addr == `SBB_DATA_ADDR)
        begin
            // RQ3 busy on same bit
            io_rdata <= {7'h00, miso_sync};
        end
        else
        begin
            io_rdata <= 8'h00;
        end
    end

    // Serial engine: one queue entry at a time keeps select and data in order
    always @*
    begin
        next_state = state;
        q_out_ready = 1'b0;
        case (state)
            ST_IDLE:
            begin
                if (q_out_valid)
                begin
                    q_out_ready = 1'b1;
                    if (!q_out_data[4])
                    begin
                        next_state = ST_LOW;
                    end
                end
            end
            ST_LOW:
            begin
                if (half_cnt == HALF - 8'h01)
                begin
                    next_state = ST_HIGH;
                end
            end
            ST_HIGH:
            begin
                if (half_cnt == HALF - 8'h01)
                begin
                    next_state = ST_IDLE;
                end
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    assign new_sel = q_out_data[3:0];
    assign load_rise = (state == ST_IDLE) && q_out_valid && q_out_data[4] &&
                       new_sel[`SBB_SEL_LOAD_BIT] && !converter_update_strobe;
    assign pot_release = (state == ST_IDLE) && q_out_valid && q_out_data[4] &&
                         !new_sel[`SBB_SEL_POT_BIT] && pot_select;
    assign sclk_rise = (state == ST_LOW) && (half_cnt == HALF - 8'h01);

    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= ST_IDLE;
            half_cnt <= 8'h00;
            serial_clk <= 1'b0;
            serial_data_out <= 1'b0;
        end
        else
        begin
            state <= next_state;
            if (state != next_state)
            begin
                half_cnt <= 8'h00;
            end
            else if (state != ST_IDLE)
            begin
                half_cnt <= half_cnt + 8'h01;
            end
            // RQ4 RQ15 shift bit zero
            if (state == ST_IDLE && q_out_valid && !q_out_data[4])
            begin
                serial_data_out <= q_out_data[0];
            end
            // RQ16 one clock pulse
            if (sclk_rise)
            begin
                serial_clk <= 1'b1;
            end
            else if (state == ST_HIGH && next_state == ST_IDLE)
            begin
                serial_clk <= 1'b0;
            end
        end
    end

    // RQ17 static select levels
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            converter_select <= 1'b0;
            pot_select <= 1'b0;
            eeprom_select <= 1'b0;
            converter_update_strobe <= 1'b0;
        end
        else if (state == ST_IDLE && q_out_valid && q_out_data[4])
        begin
            // RQ13 converter select
            converter_select <= new_sel[`SBB_SEL_CONV_BIT];
            // RQ12 pot select
            pot_select <= new_sel[`SBB_SEL_POT_BIT];
            // RQ11 eeprom select
            eeprom_select <= new_sel[`SBB_SEL_EE_BIT];
            converter_update_strobe <= new_sel[`SBB_SEL_LOAD_BIT];
        end
    end

    // Converter and pot receivers shift on the serial clock rising edge
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            converter_shift_word <= {`SBB_CONV_WORD_W{1'b0}};
            pot_shift_word <= {`SBB_POT_WORD_W{1'b0}};
        end
        else if (sclk_rise)
        begin
            // RQ13 write-only converter
            if (converter_select)
            begin
                converter_shift_word <= {converter_shift_word[`SBB_CONV_WORD_W-2:0], serial_data_out};
            end
            // RQ12 pot shifts when selected
            if (pot_select)
            begin
                pot_shift_word <= {pot_shift_word[`SBB_POT_WORD_W-2:0], serial_data_out};
            end
        end
    end

    // RQ14 two output data registers
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            out0_value <= {`SBB_CONV_DATA_W{1'b0}};
            out1_value <= {`SBB_CONV_DATA_W{1'b0}};
        end
        // RQ7 load on rise
        else if (load_rise)
        begin
            // RQ9 flagged channels only
            if (converter_shift_word[`SBB_CONV_A_BIT])
            begin
                out0_value <= converter_shift_word[`SBB_CONV_DATA_W-1:0];
            end
            if (converter_shift_word[`SBB_CONV_B_BIT])
            begin
                out1_value <= converter_shift_word[`SBB_CONV_DATA_W-1:0];
            end
        end
        // RQ8 outputs hold otherwise
    end

    // RQ14 four calibration pots
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            input_offset_pot <= {`SBB_POT_VAL_W{1'b0}};
            out0_gain_pot <= {`SBB_POT_VAL_W{1'b0}};
            input_gain_pot <= {`SBB_POT_VAL_W{1'b0}};
            out1_gain_pot <= {`SBB_POT_VAL_W{1'b0}};
        end
        else if (pot_release)
        begin
            // Wiper commits when the pot chip is deselected, like a real chip
            case (pot_shift_word[`SBB_POT_WORD_W-1:`SBB_POT_VAL_W])
                2'b00:
                begin
                    input_offset_pot <= pot_shift_word[`SBB_POT_VAL_W-1:0];
                end
                2'b01:
                begin
                    out0_gain_pot <= pot_shift_word[`SBB_POT_VAL_W-1:0];
                end
                2'b10:
                begin
                    input_gain_pot <= pot_shift_word[`SBB_POT_VAL_W-1:0];
                end
                default:
                begin
                    out1_gain_pot <= pot_shift_word[`SBB_POT_VAL_W-1:0];
                end
            endcase
        end
    end
    // EEPROM framing rides the same data and clock pins, one bit per write
endmodule // sbb_serial_port

// >>> tb/sbb_far_side.sv
// Far-side model: serial EEPROM echo and clock pulse tally
`timescale 1ns/1ps
module sbb_far_side (
    // Clock
    input wire core_clk,
    // Serial bus
    input wire serial_clk,
    input wire serial_data_out,
    input wire eeprom_select,
    output reg serial_data_in,
    // Pulse tally
    output integer n_pulses
);
    reg clk_q = 1'b0;
    reg last_bit = 1'b0;
    initial n_pulses = 0;
    initial serial_data_in = 1'b0;
    always @(posedge core_clk)
    begin
        clk_q <= serial_clk;
        if (serial_clk && !clk_q)
        begin
            n_pulses <= n_pulses + 1;
            if (eeprom_select)
                last_bit <= serial_data_out;
        end
        // released line shows the inverse so a stale value cannot pass
        serial_data_in <= eeprom_select ? last_bit : ~last_bit;
    end
endmodule // sbb_far_side

// >>> tb/sbb_port_sva.sv
// Assertion checker for the serial port select block
`timescale 1ns/1ps
module sbb_port_sva #(
    parameter SCLK_HALF_CYC = 4
) (
    // Clock and reset
    input wire core_clk,
    input wire reset_n,
    // Host port
    input wire [9:0] io_addr,
    input wire io_rd,
    input wire [7:0] io_rdata,
    input wire io_ready,
    // Serial bus
    input wire serial_clk,
    input wire serial_data_out,
    input wire eeprom_select,
    input wire pot_select,
    input wire converter_select,
    input wire converter_update_strobe,
    input wire [11:0] out0_value,
    input wire [11:0] out1_value,
    input wire serial_busy
);
    reg [7:0] hi_cnt;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            hi_cnt <= 8'h00;
        else
            hi_cnt <= serial_clk ? hi_cnt + 8'h01 : 8'h00;
    end
    sequence s_quiet;
        !serial_busy ##1 !serial_busy;
    endsequence
    property p_clk_idle;
        !serial_busy |-> !serial_clk;
    endproperty
    a_clk_idle: assert property (p_clk_idle) else $error("serial clock high while idle");
    property p_clk_high;
        $fell(serial_clk) |-> hi_cnt == SCLK_HALF_CYC;
    endproperty
    a_clk_high: assert property (p_clk_high) else $error("serial clock high time wrong");
    property p_data_stable;
        serial_clk |-> $stable(serial_data_out);
    endproperty
    a_data_stable: assert property (p_data_stable) else $error("data moved while clock high");
    property p_rd_idle;
        !(io_rd && io_addr == 10'h309) |=> io_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside a read");
    property p_rd_upper;
        io_rd |=> io_rdata[7:1] == 7'h00;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
    property p_out_hold;
        $changed({out0_value, out1_value}) |-> $rose(converter_update_strobe);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("output moved without load edge");
    property p_sel_static;
        s_quiet |-> $stable({eeprom_select, pot_select, converter_select, converter_update_strobe});
    endproperty
    a_sel_static: assert property (p_sel_static) else $error("select level moved while idle");
    property p_full_busy;
        !io_ready |-> serial_busy;
    endproperty
    a_full_busy: assert property (p_full_busy) else $error("queue full but not busy");
endmodule // sbb_port_sva
bind sbb_serial_port sbb_port_sva #(.SCLK_HALF_CYC(SCLK_HALF_CYC)) sva_u (
    .core_clk(core_clk), .reset_n(reset_n), .io_addr(io_addr), .io_rd(io_rd), .io_rdata(io_rdata),
    .io_ready(io_ready), .serial_clk(serial_clk), .serial_data_out(serial_data_out),
    .eeprom_select(eeprom_select), .pot_select(pot_select), .converter_select(converter_select),
    .converter_update_strobe(converter_update_strobe), .out0_value(out0_value),
    .out1_value(out1_value), .serial_busy(serial_busy)
);

// >>> tb/testbench.sv
// Self-checking bench for the serial port select block
`timescale 1ns/1ps
module testbench;
    reg core_clk = 1'b0;
    reg reset_n = 1'b0;
    reg [9:0] io_addr = 10'h000;
    reg io_wr = 1'b0;
    reg io_rd = 1'b0;
    reg [7:0] io_wdata = 8'h00;
    wire [7:0] io_rdata;
    wire io_ready, serial_clk, serial_data_out, serial_data_in, serial_busy;
    wire eeprom_select, pot_select, converter_select, converter_update_strobe;
    wire [11:0] out0_value, out1_value;
    wire [7:0] pot_q [0:3];
    integer miscompares = 0;
    integer n_checks = 0;
    integer n_pulses, w, i;
    integer n_bits = 0;
    reg [11:0] e0 = 12'h000, e1 = 12'h000, v;
    reg [7:0] rd_v, pv;
    reg b, saw_full;
    always #25 core_clk = ~core_clk;
    sbb_serial_port #(.SCLK_HALF_CYC(4)) dut_u (
        .core_clk(core_clk), .reset_n(reset_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .io_ready(io_ready), .serial_clk(serial_clk),
        .serial_data_out(serial_data_out), .serial_data_in(serial_data_in), .eeprom_select(eeprom_select),
        .pot_select(pot_select), .converter_select(converter_select),
        .converter_update_strobe(converter_update_strobe), .out0_value(out0_value), .out1_value(out1_value),
        .input_offset_pot(pot_q[0]), .out0_gain_pot(pot_q[1]), .input_gain_pot(pot_q[2]),
        .out1_gain_pot(pot_q[3]), .serial_busy(serial_busy)
    );
    sbb_far_side far_u (
        .core_clk(core_clk), .serial_clk(serial_clk), .serial_data_out(serial_data_out),
        .eeprom_select(eeprom_select), .serial_data_in(serial_data_in), .n_pulses(n_pulses)
    );
    task chk(input string name, input [31:0] seen, input [31:0] exp);
    begin
        n_checks = n_checks + 1;
        if (seen !== exp)
        begin
            miscompares = miscompares + 1;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    end
    endtask
    // Expected converter pair after a load with the given target bits
    function [23:0] load_exp(input [1:0] tgt, input [11:0] val, input [23:0] prev);
    begin
        load_exp = {tgt[1] ? val : prev[23:12], tgt[0] ? val : prev[11:0]};
    end
    endfunction
    // Strobe stays up between back-to-back writes; settle drops it
    task wr(input [9:0] a, input [7:0] d);
    begin
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        while (io_ready !== 1'b1)
        begin
            @(posedge core_clk);
            #2;
        end
        @(posedge core_clk);
        #2;
    end
    endtask
    task shift(input [15:0] wd, input integer n);
        integer j;
    begin
        for (j = n - 1; j >= 0; j = j - 1)
            wr(10'h309, {7'($urandom), wd[j]});
        n_bits = n_bits + n;
    end
    endtask
    task settle;
    begin
        io_wr = 1'b0;
        repeat (2) @(posedge core_clk);
        #2;
        for (w = 0; w < 400 && serial_busy !== 1'b0; w = w + 1)
        begin
            @(posedge core_clk);
            #2;
        end
        // A stuck engine counts against the run
        if (w == 400)
            miscompares = miscompares + 1;
        repeat (3) @(posedge core_clk);
        #2;
    end
    endtask
    task rd(input [9:0] a);
    begin
        @(posedge core_clk);
        #2;
        io_addr = a;
        io_rd = 1'b1;
        @(posedge core_clk);
        #2;
        io_rd = 1'b0;
        rd_v = io_rdata;
    end
    endtask
    task summarize;
    begin
        if (miscompares == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask
    initial
    begin
        #2000000;
        miscompares = miscompares + 1;
        summarize;
    end
    initial
    begin
        void'($urandom(66830));
        repeat (5) @(posedge core_clk);
        #2;
        reset_n = 1'b1;
        chk("rst_sel", {eeprom_select, pot_select, converter_select, converter_update_strobe}, 0);
        chk("rst_out", {out0_value, out1_value, io_ready}, 1);
        // select codes 0 to 7 (load bit clear) with random unused bits
        for (i = 0; i < 8; i = i + 1)
        begin
            wr(10'h308, {4'($urandom), i[3:0]});
            settle;
            chk("sel", {converter_update_strobe, eeprom_select, pot_select, converter_select}, i);
        end
        for (i = 0; i < 4; i = i + 1)
        begin
            v = 12'($urandom);
            // load back to zero before new data
            wr(10'h308, 8'h01);
            shift({i[1:0], v}, 14);
            settle;
            chk("hold", {out0_value, out1_value}, {e0, e1});
            wr(10'h308, 8'h09);
            settle;
            {e0, e1} = load_exp(i[1:0], v, {e0, e1});
            chk("load", {out0_value, out1_value}, {e0, e1});
            shift({2'b11, ~v}, 14);
            wr(10'h308, 8'h09);
            settle;
            chk("no_edge", {out0_value, out1_value}, {e0, e1});
        end
        for (i = 0; i < 4; i = i + 1)
        begin
            pv = 8'($urandom);
            wr(10'h308, 8'h02);
            shift({i[1:0], pv}, 10);
            wr(10'h308, 8'h00);
            settle;
            chk("pot", pot_q[i], pv);
        end
        for (i = 0; i < 2; i = i + 1)
        begin
            b = 1'($urandom);
            wr(10'h308, 8'h04);
            shift({15'h0000, b}, 1);
            wr(10'h308, 8'h00);
            shift({15'h0000, ~b}, 1);
            wr(10'h308, 8'h04);
            settle;
            rd(10'h309);
            chk("rdat", rd_v, {7'h00, b});
            rd(10'h308);
            chk("rd_other", rd_v, 0);
        end
        chk("pulses", n_pulses, n_bits);
        saw_full = 1'b0;
        io_addr = 10'h309;
        io_wr = 1'b1;
        // Writes outpace the serial engine, so the queue must push back
        repeat (24)
        begin
            @(posedge core_clk);
            #2;
            if (io_ready === 1'b0)
                saw_full = 1'b1;
        end
        settle;
        chk("full", saw_full, 1);
        chk("drained", {io_ready, serial_busy}, 2'b10);
        summarize;
    end
endmodule // testbench
